// file: design/dbg_link_pkg.sv
package dbg_link_pkg;

    // target_select codes
    localparam logic [7:0] SEL_PART_ID = 8'h00;
    localparam logic [7:0] SEL_REVISION = 8'h01;
    localparam logic [7:0] SEL_UNLOCK_CTL = 8'h02;
    localparam logic [7:0] SEL_PROG_DATA = 8'had;

    // reset values and unmapped read value
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // unlock sequence
    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;

    // programming data port command codes
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

    // frame layout: two instruction bits then eight data bits, msb first
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] INSTR_LAST = 4'h1;
    localparam logic [3:0] FRAME_LAST = 4'h9;

    // link idle timeout that resynchronises framing
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int IDLE_TIMEOUT_NS = 20_000;
    localparam int IDLE_CYC_INT = (IDLE_TIMEOUT_NS / 1000) * (SYS_CLK_HZ / 1_000_000);
    localparam logic [9:0] IDLE_CYC = 10'(IDLE_CYC_INT);
    localparam logic [9:0] IDLE_ZERO = 10'h000;
    localparam logic [9:0] IDLE_ONE = 10'h001;

    typedef enum logic [1:0] {
        INS_DATA_READ = 2'b00,
        INS_DATA_WRITE = 2'b01,
        INS_ADDR_WRITE = 2'b10,
        INS_ADDR_READ = 2'b11
    } instr_t;

    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_OPEN = 2'b10
    } unlock_t;

    function automatic logic is_command(input logic [7:0] b);
        return (b == CMD_BLOCK_READ) || (b == CMD_BLOCK_WRITE) ||
               (b == CMD_PAGE_ERASE) || (b == CMD_DEVICE_ERASE);
    endfunction : is_command

endpackage : dbg_link_pkg

// file: design/link_pin_sync.sv
`timescale 1ns/1ps
module link_pin_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // pin and synchronised view
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic prev;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_in;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule : link_pin_sync

// file: design/debug_link_register_access.sv
// How it works
// - one host clock, one shared data line
// - eight-bit target_select loaded over the link
// - select zero reads part identification
// - select one reads silicon revision
// - select two reaches unlock control register
// - select ad reaches programming data port
// - part identification is fixed, read only
// - silicon revision is fixed, read only
// - writes two then one enable programming
// - programming stays enabled until system reset
// - data port passes commands, addresses, data
// - core stalled while link is busy
`timescale 1ns/1ps
module debug_link_register_access #(
    parameter logic [7:0] PART_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h11 // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // link pins
    input wire logic link_clock_pin,
    input wire logic link_data_pin_in,
    output logic link_data_pin_out,
    output logic link_data_pin_oe,
    // programming data port
    output logic prog_wr,
    output logic [7:0] prog_wdata,
    output logic prog_cmd_valid,
    output logic prog_rd,
    input wire logic [7:0] prog_rdata,
    // system status
    output logic programming_enabled,
    output logic core_stall
);
    import dbg_link_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic lk_rise;
    logic lk_fall;
    logic din;

    link_pin_sync u_clk_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(link_clock_pin),
        .level(),
        .rise(lk_rise),
        .fall(lk_fall)
    );

    link_pin_sync u_data_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(link_data_pin_in),
        .level(din),
        .rise(),
        .fall()
    );

    ////////////////////////////////////////////////////////////////////////
    // frame state
    logic [3:0] bit_cnt;
    logic [1:0] instr;
    logic [7:0] shift;
    logic [9:0] idle_cnt;
    logic [7:0] target_select;
    logic [7:0] programming_unlock_control;
    logic [7:0] rd_byte;
    logic rd_frame;
    unlock_t unlock;

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire instr_done = lk_rise && (bit_cnt == INSTR_LAST);
    wire frame_done = lk_rise && (bit_cnt == FRAME_LAST);
    wire idle_expired = (idle_cnt == IDLE_CYC);
    wire [1:0] full_instr = {instr[0], din};
    wire [7:0] next_byte = {shift[6:0], din};
    wire commit_data_wr = frame_done && (instr == INS_DATA_WRITE);
    wire commit_addr_wr = frame_done && (instr == INS_ADDR_WRITE);
    wire commit_ctl = commit_data_wr && (target_select == SEL_UNLOCK_CTL);
    wire commit_prog = commit_data_wr && (target_select == SEL_PROG_DATA);
    wire starts_read = instr_done &&
        ((full_instr == INS_DATA_READ) || (full_instr == INS_ADDR_READ));
    wire [3:0] next_bit_cnt = (frame_done || idle_expired) ? BIT_CNT_ZERO :
        (lk_rise ? bit_cnt + 4'h1 : bit_cnt);
    wire [2:0] drive_idx = 3'(FRAME_LAST - bit_cnt);
    wire drive_now = rd_frame && (bit_cnt > INSTR_LAST);

    // read mux
    logic [7:0] data_read;
    assign data_read = (target_select == SEL_PART_ID) ? PART_CODE :
        (target_select == SEL_REVISION) ? REVISION_CODE :
        (target_select == SEL_UNLOCK_CTL) ? programming_unlock_control :
        (target_select == SEL_PROG_DATA) ? prog_rdata :
        UNMAPPED_READ;
    wire [7:0] next_rd_byte = (full_instr == INS_ADDR_READ) ? target_select : data_read;

    // unlock sequence
    logic [1:0] next_unlock_code;
    unlock_t next_unlock;
    always_comb begin
        next_unlock = unlock;
        case (unlock)
            UNLOCK_IDLE: begin
                if (commit_ctl && next_byte == UNLOCK_FIRST) begin
                    next_unlock = UNLOCK_HALF;
                end
            end
            UNLOCK_HALF: begin
                if (commit_ctl) begin
                    if (next_byte == UNLOCK_SECOND) begin
                        next_unlock = UNLOCK_OPEN;
                    end else if (next_byte == UNLOCK_FIRST) begin
                        next_unlock = UNLOCK_HALF;
                    end else begin
                        next_unlock = UNLOCK_IDLE;
                    end
                end
            end
            UNLOCK_OPEN: next_unlock = UNLOCK_OPEN;
            default: next_unlock = UNLOCK_IDLE;
        endcase
    end
    assign next_unlock_code = next_unlock;

    ////////////////////////////////////////////////////////////////////////
    // framing and shifting
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bit_cnt <= BIT_CNT_ZERO;
            instr <= INS_DATA_READ;
            shift <= CTL_RESET;
            idle_cnt <= IDLE_ZERO;
        end else begin
            bit_cnt <= next_bit_cnt;
            idle_cnt <= (lk_rise || lk_fall || idle_expired) ? IDLE_ZERO : idle_cnt + IDLE_ONE;
            if (lk_rise && bit_cnt <= INSTR_LAST) begin
                instr <= full_instr;
            end else if (lk_rise) begin
                shift <= next_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            target_select <= SEL_RESET;
            programming_unlock_control <= CTL_RESET;
            unlock <= UNLOCK_IDLE;
            programming_enabled <= 1'b0;
        end else begin
            if (commit_addr_wr) begin
                target_select <= next_byte;
            end
            if (commit_ctl) begin
                programming_unlock_control <= next_byte;
            end
            unlock <= next_unlock;
            programming_enabled <= programming_enabled ||
                (next_unlock_code == UNLOCK_OPEN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read drive and programming port
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_byte <= UNMAPPED_READ;
            rd_frame <= 1'b0;
            link_data_pin_out <= 1'b0;
            link_data_pin_oe <= 1'b0;
            prog_wr <= 1'b0;
            prog_wdata <= CTL_RESET;
            prog_cmd_valid <= 1'b0;
            prog_rd <= 1'b0;
            core_stall <= 1'b0;
        end else begin
            if (starts_read) begin
                rd_byte <= next_rd_byte;
            end
            if (instr_done) begin
                rd_frame <= starts_read;
            end else if (frame_done || idle_expired) begin
                rd_frame <= 1'b0;
            end
            if (idle_expired) begin
                link_data_pin_oe <= 1'b0;
            end else if (lk_fall) begin
                link_data_pin_oe <= drive_now;
                link_data_pin_out <= drive_now & rd_byte[drive_idx];
            end
            prog_wr <= commit_prog;
            if (commit_prog) begin
                prog_wdata <= next_byte;
                prog_cmd_valid <= is_command(next_byte);
            end
            prog_rd <= starts_read && (full_instr == INS_DATA_READ) &&
                (target_select == SEL_PROG_DATA);
            core_stall <= programming_enabled || (next_bit_cnt != BIT_CNT_ZERO);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_first_written;
        commit_ctl && unlock == UNLOCK_IDLE && next_byte == UNLOCK_FIRST;
    endsequence
    sequence s_second_written;
        commit_ctl && next_byte == UNLOCK_SECOND;
    endsequence

    a_unlock_half_step: assert property (s_first_written |=> unlock == UNLOCK_HALF)
        else $error("first unlock byte not taken");
    a_unlock_pair_open: assert property (unlock == UNLOCK_HALF ##0 s_second_written
        |=> ##1 programming_enabled)
        else $error("unlock pair did not enable programming");
    a_no_early_enable: assert property ($rose(programming_enabled)
        |-> $past(unlock, 2) == UNLOCK_HALF)
        else $error("programming enabled without ordered pair");
    a_enable_sticky: assert property (programming_enabled |=> programming_enabled)
        else $error("programming enable dropped before reset");
    a_wrong_restart: assert property (commit_ctl && unlock == UNLOCK_HALF &&
        next_byte != UNLOCK_FIRST && next_byte != UNLOCK_SECOND
        |=> unlock == UNLOCK_IDLE ##1 !programming_enabled)
        else $error("wrong unlock byte did not restart");
    a_select_load: assert property (commit_addr_wr |=> target_select == $past(next_byte))
        else $error("target select not loaded");
    a_part_read: assert property (starts_read && full_instr == INS_DATA_READ &&
        target_select == SEL_PART_ID |=> rd_byte == PART_CODE)
        else $error("part identification not returned");
    a_rev_read: assert property (starts_read && full_instr == INS_DATA_READ &&
        target_select == SEL_REVISION |=> rd_byte == REVISION_CODE)
        else $error("revision not returned");
    a_prog_write: assert property (commit_prog |=> prog_wr &&
        prog_wdata == $past(next_byte))
        else $error("programming data write not passed");
    // the last read bit stands until the fall after the closing rise, once rd_frame has dropped
    a_drive_in_read: assert property (link_data_pin_oe |->
        rd_frame || (bit_cnt == BIT_CNT_ZERO))
        else $error("data line driven outside a read");
    a_stall_held: assert property (programming_enabled |=> core_stall)
        else $error("core not stalled while programming");
endmodule : debug_link_register_access

// file: tb/link_host.sv
`timescale 1ns/1ps
module link_host (
    // clock
    input wire logic sys_clk,
    // link pins
    output logic link_clock_pin,
    output logic host_oe,
    output logic host_out,
    input wire logic wire_level
);
    ////////////////////////////////////////
    initial begin
        link_clock_pin = 1'b0;
        host_oe = 1'b1;
        host_out = 1'b0;
    end
    ////////////////////////////////////////
    // one frame: two instruction bits then a byte, msb first
    task automatic frame(input logic [1:0] ins, input logic [7:0] wb, output logic [7:0] rb);
        logic [9:0] bits;
        bits = {ins, wb};
        rb = 8'h00;
        for (int i = 9; i >= 0; i--) begin
            host_oe = (i > 7) || (ins[0] ^ ins[1]);
            host_out = bits[i];
            repeat (4) @(negedge sys_clk);
            link_clock_pin = 1'b1;
            if (i < 8) rb[i] = wire_level;
            repeat (4) @(negedge sys_clk);
            link_clock_pin = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        host_oe = 1'b1;
    endtask : frame
endmodule : link_host

// file: tb/tb_debug_link_register_access.sv
`timescale 1ns/1ps
module tb_debug_link_register_access;
    import dbg_link_pkg::*;
    localparam logic [7:0] PART = 8'h4b; // arbitrary value
    localparam logic [7:0] REV = 8'h19; // arbitrary value
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic link_clock_pin, link_data_pin_out, link_data_pin_oe, host_oe, host_out;
    logic last_level = 1'b0;
    logic prog_wr, prog_cmd_valid, prog_rd, programming_enabled, core_stall;
    logic [7:0] prog_wdata, rd_b, dummy;
    logic [7:0] prog_rdata = 8'h3c;
    logic [7:0] cmds [5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h55};
    int errors = 0;
    int checks = 0;
    int wr_seen = 0;
    int rd_seen = 0;
    // undriven line toggles instead of holding its last value
    wire logic data_level = link_data_pin_oe ? link_data_pin_out :
        (host_oe ? host_out : ~last_level);
    ////////////////////////////////////////
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        last_level <= data_level;
        if (prog_wr === 1'b1) wr_seen <= wr_seen + 1;
        if (prog_rd === 1'b1) rd_seen <= rd_seen + 1;
    end
    debug_link_register_access #(.PART_CODE(PART), .REVISION_CODE(REV)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .link_clock_pin(link_clock_pin),
        .link_data_pin_in(data_level), .link_data_pin_out(link_data_pin_out),
        .link_data_pin_oe(link_data_pin_oe), .prog_wr(prog_wr), .prog_wdata(prog_wdata),
        .prog_cmd_valid(prog_cmd_valid), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
        .programming_enabled(programming_enabled), .core_stall(core_stall)
    );
    link_host u_host (
        .sys_clk(sys_clk), .link_clock_pin(link_clock_pin), .host_oe(host_oe),
        .host_out(host_out), .wire_level(data_level)
    );
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] sel, input logic [7:0] val);
        u_host.frame(INS_ADDR_WRITE, sel, dummy);
        u_host.frame(INS_DATA_WRITE, val, dummy);
    endtask : wr
    task automatic rd(input logic [7:0] sel, output logic [7:0] val);
        u_host.frame(INS_ADDR_WRITE, sel, dummy);
        u_host.frame(INS_DATA_READ, 8'h00, val);
    endtask : rd
    task automatic do_reset;
        rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : do_reset
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        results();
    end
    initial begin
        do_reset();
        chk("enabled", 8'h00, {7'h00, programming_enabled});
        chk("stall", 8'h00, {7'h00, core_stall});
        chk("oe", 8'h00, {7'h00, link_data_pin_oe});
        rd(8'h00, rd_b);
        chk("part", PART, rd_b);
        wr(8'h00, 8'hff);
        rd(8'h00, rd_b);
        chk("part ro", PART, rd_b);
        wr(8'h01, 8'hff);
        rd(8'h01, rd_b);
        chk("revision", REV, rd_b);
        u_host.frame(INS_ADDR_READ, 8'h00, rd_b);
        chk("select", 8'h01, rd_b);
        rd(8'h33, rd_b);
        chk("unmapped", 8'h00, rd_b);
        $display("test identity done");
        foreach (cmds[i]) begin
            wr(8'had, cmds[i]);
            chk("wdata", cmds[i], prog_wdata);
            chk("cmd", {7'h00, i < 4}, {7'h00, prog_cmd_valid});
        end
        chk("writes", 8'h05, 8'(wr_seen));
        rd(8'had, rd_b);
        chk("rdata", 8'h3c, rd_b);
        chk("reads", 8'h01, 8'(rd_seen));
        $display("test data port done");
        wr(8'h02, 8'h01);
        wr(8'h02, 8'h02);
        wr(8'h02, 8'h05);
        rd(8'h02, rd_b);
        chk("control", 8'h05, rd_b);
        u_host.frame(INS_DATA_WRITE, 8'h01, dummy);
        chk("enabled", 8'h00, {7'h00, programming_enabled});
        u_host.frame(INS_DATA_WRITE, 8'h02, dummy);
        u_host.frame(INS_DATA_WRITE, 8'h01, dummy);
        chk("enabled", 8'h01, {7'h00, programming_enabled});
        chk("stall", 8'h01, {7'h00, core_stall});
        u_host.frame(INS_DATA_WRITE, 8'h00, dummy);
        chk("sticky", 8'h01, {7'h00, programming_enabled});
        do_reset();
        chk("enabled", 8'h00, {7'h00, programming_enabled});
        rd(8'h02, rd_b);
        chk("control reset", 8'h00, rd_b);
        $display("test unlock done");
        results();
    end
endmodule : tb_debug_link_register_access
